// ---- include/charger_regs_pkg.sv ----
// Shared constants and types for the charger register block
package charger_regs_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [5:0] IDX_POST_CTRL = 6'h07;
  localparam logic [5:0] IDX_MON_FIRST = 6'h10;
  localparam logic [5:0] IDX_MON_SECOND = 6'h11;

  // Reset values
  localparam logic [7:0] POST_CTRL_RST = 8'h01;
  localparam logic POK_RELEASE_RST = 1'b0;

  // Post-charging control field positions
  localparam int LOAD_SEL_LSB = 4;
  localparam int BG_EN_BIT = 3;
  localparam int TERM_LSB = 0;

  // First monitor register bit positions
  localparam int MF_TERM_BIT = 7;
  localparam int MF_BAT_BELOW_BIT = 6;
  localparam int MF_TRICKLE_BIT = 5;
  localparam int MF_HOT_BIT = 4;
  localparam int MF_CHG_LOOP_BIT = 3;
  localparam int MF_IN_LOOP_BIT = 2;
  localparam int MF_SUPPLY_OK_BIT = 1;
  localparam int MF_CONST_V_BIT = 0;

  // Second monitor register bit positions
  localparam int MS_GATE_BIT = 7;
  localparam int MS_BAT_OK_BIT = 6;
  localparam int MS_POK_BIT = 5;
  localparam int MS_DISABLE_BIT = 4;
  localparam int MS_ABSENT_BIT = 3;
  localparam int MS_BG_ACTIVE_BIT = 2;

  // Input-loading codes
  localparam logic [1:0] LOAD_NONE = 2'h0;
  localparam logic [1:0] LOAD_SHORT = 2'h1;
  localparam logic [1:0] LOAD_MED = 2'h2;
  localparam logic [1:0] LOAD_LONG = 2'h3;

  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int LOAD_SHORT_MS = 4;
  localparam int LOAD_MED_MS = 131;
  localparam int LOAD_LONG_MS = 135;
  localparam int LOAD_PERIOD_S = 2;
  localparam int LOAD_SHORT_CYCLES = LOAD_SHORT_MS * (CLK_HZ / 1000);
  localparam int LOAD_MED_CYCLES = LOAD_MED_MS * (CLK_HZ / 1000);
  localparam int LOAD_LONG_CYCLES = LOAD_LONG_MS * (CLK_HZ / 1000);
  localparam int LOAD_PERIOD_CYCLES = LOAD_PERIOD_S * CLK_HZ;
  localparam int LOAD_CNT_W = 25;

  // Number of asynchronous status inputs
  localparam int STATUS_W = 15;

  typedef enum logic [2:0] {
    LD_IDLE = 3'h1,
    LD_ON = 3'h2,
    LD_REST = 3'h4
  } load_state_t;

endpackage

// ---- design/sync_2ff.sv ----
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // First stage feeds the second stage only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ---- design/charger_postcharge_monitor_regs.sv ----
// Post-charging control and charger monitor registers on APB
//
// Functional notes
// - Post-charging control bits 7:6 always read zero.
// - Input loading acts only in the charge-done state.
// - Load code picks none, 4 ms, 131 ms or 135 ms every two seconds.
// - Bit 3 enables background charging; resets to zero.
// - Bits 2:0 set background termination current, 50 mA steps, reset 001.
// - Post-charging control sits at index 07h, resets to 01h.
// - First monitor bit 7 shows termination comparator.
// - First monitor bit 6 shows battery below input supply.
// - First monitor bit 5 shows short-battery trickle charger active.
// - First monitor bit 4 shows die over temperature; core caps current.
// - First monitor bit 3 low while charge-current loop governs.
// - First monitor bit 2 low while input-current loop governs.
// - First monitor bit 1 shows input supply validated.
// - First monitor bit 0 shows constant-voltage loop in control.
// - Second monitor bit 7 shows external gate pin level.
// - Second monitor bit 6 shows battery above its threshold.
// - Second monitor bit 5 mirrors power-good pin; setting it releases only while bit 6 is clear.
// - Second monitor bit 4 shows disable pin level.
// - Second monitor bit 3 shows no battery detected.
// - Second monitor bit 2 shows background charging in progress.
`timescale 1ns/1ps
module charger_postcharge_monitor_regs #(
  parameter int LOAD_SHORT_CYC = charger_regs_pkg::LOAD_SHORT_CYCLES,
  parameter int LOAD_MED_CYC = charger_regs_pkg::LOAD_MED_CYCLES,
  parameter int LOAD_LONG_CYC = charger_regs_pkg::LOAD_LONG_CYCLES,
  parameter int LOAD_PERIOD_CYC = charger_regs_pkg::LOAD_PERIOD_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Status levels from the analog core and pins
  input wire logic termination_compare_flag,
  input wire logic battery_below_input_flag,
  input wire logic linear_trickle_active,
  input wire logic die_hot_flag,
  input wire logic charge_loop_flag,
  input wire logic input_current_loop_flag,
  input wire logic input_supply_ok,
  input wire logic const_voltage_flag,
  input wire logic gate_pin_state,
  input wire logic battery_above_low_flag,
  input wire logic disable_pin,
  input wire logic battery_absent_flag,
  input wire logic background_charge_active,
  input wire logic charge_done_state,
  // Power-good open-drain pin
  input wire logic power_good_pin_in,
  input wire logic power_good_low_req,
  output logic power_good_pin_out,
  output logic power_good_pin_oe,
  // Controls to the charger core
  output logic input_load_on,
  output logic background_charge_enable,
  output logic [2:0] background_term_current
);
  import charger_regs_pkg::*;

  // Synchronised status
  logic [STATUS_W-1:0] status_raw;
  logic [STATUS_W-1:0] status_s;
  logic term_s, bat_below_s, trickle_s, hot_s, chg_loop_s, in_loop_s;
  logic supply_ok_s, const_v_s, gate_s, bat_ok_s, pok_s, disable_s;
  logic absent_s, bg_active_s, done_s;

  assign status_raw = {termination_compare_flag, battery_below_input_flag,
                       linear_trickle_active, die_hot_flag,
                       charge_loop_flag, input_current_loop_flag,
                       input_supply_ok, const_voltage_flag,
                       gate_pin_state, battery_above_low_flag,
                       power_good_pin_in, disable_pin,
                       battery_absent_flag, background_charge_active,
                       charge_done_state};

  sync_2ff #(.W(STATUS_W)) u_status_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(status_raw),
    .sync_out(status_s)
  );

  assign {term_s, bat_below_s, trickle_s, hot_s, chg_loop_s, in_loop_s,
          supply_ok_s, const_v_s, gate_s, bat_ok_s, pok_s, disable_s,
          absent_s, bg_active_s, done_s} = status_s;

  // Register storage
  logic [7:0] post_ctrl_reg, post_ctrl_view, mon_first, mon_second;
  logic pok_release_reg;

  // APB decode
  logic hit_post, hit_first, hit_second, hit_any, access, wr_en;
  logic [7:0] rd_mux;

  assign hit_post = (paddr[7:2] == IDX_POST_CTRL) && (paddr[1:0] == 2'h0);
  assign hit_first = (paddr[7:2] == IDX_MON_FIRST) && (paddr[1:0] == 2'h0);
  assign hit_second = (paddr[7:2] == IDX_MON_SECOND) && (paddr[1:0] == 2'h0);
  assign hit_any = hit_post || hit_first || hit_second;
  assign access = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && hit_any;

  // Reserved bits never stored, so they read zero
  assign post_ctrl_view = {2'h0, post_ctrl_reg[5:0]};

  // Monitor views follow the live synchronised levels
  always_comb begin
    mon_first = 8'h00;
    mon_first[MF_TERM_BIT] = term_s;
    mon_first[MF_BAT_BELOW_BIT] = bat_below_s;
    mon_first[MF_TRICKLE_BIT] = trickle_s;
    mon_first[MF_HOT_BIT] = hot_s;
    mon_first[MF_CHG_LOOP_BIT] = chg_loop_s;
    mon_first[MF_IN_LOOP_BIT] = in_loop_s;
    mon_first[MF_SUPPLY_OK_BIT] = supply_ok_s;
    mon_first[MF_CONST_V_BIT] = const_v_s;
    mon_second = 8'h00;
    mon_second[MS_GATE_BIT] = gate_s;
    mon_second[MS_BAT_OK_BIT] = bat_ok_s;
    mon_second[MS_POK_BIT] = pok_s;
    mon_second[MS_DISABLE_BIT] = disable_s;
    mon_second[MS_ABSENT_BIT] = absent_s;
    mon_second[MS_BG_ACTIVE_BIT] = bg_active_s;
  end

  always_comb begin
    rd_mux = 8'h00;
    if (hit_post) begin
      rd_mux = post_ctrl_view;
    end else if (hit_first) begin
      rd_mux = mon_first;
    end else if (hit_second) begin
      rd_mux = mon_second;
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      if (access) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
        pslverr <= !hit_any;
      end
    end
  end

  // Post-charging control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      post_ctrl_reg <= POST_CTRL_RST;
    end else if (wr_en && hit_post) begin
      post_ctrl_reg <= {2'h0, pwdata[5:0]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      background_charge_enable <= POST_CTRL_RST[BG_EN_BIT];
      background_term_current <= POST_CTRL_RST[TERM_LSB +: 3];
    end else if (wr_en && hit_post) begin
      background_charge_enable <= pwdata[BG_EN_BIT];
      background_term_current <= pwdata[TERM_LSB +: 3];
    end
  end

  // Power-good release; only accepted once the battery is low.
  // Writing zero hands the pin back to the core.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pok_release_reg <= POK_RELEASE_RST;
    end else if (wr_en && hit_second) begin
      if (!pwdata[MS_POK_BIT]) begin
        pok_release_reg <= 1'b0;
      end else if (!bat_ok_s) begin
        pok_release_reg <= 1'b1;
      end
    end
  end

  // Open drain: only ever drives low
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_good_pin_out <= 1'b0;
      power_good_pin_oe <= 1'b0;
    end else begin
      power_good_pin_out <= 1'b0;
      power_good_pin_oe <= power_good_low_req && !pok_release_reg;
    end
  end

  // Input-loading pulse timer
  load_state_t state_reg, state_next;
  logic [LOAD_CNT_W-1:0] cnt_reg, cnt_next, load_len;
  logic [1:0] load_sel;
  logic load_armed;

  assign load_sel = post_ctrl_reg[LOAD_SEL_LSB +: 2];
  assign load_armed = done_s && (load_sel != LOAD_NONE);

  always_comb begin
    case (load_sel)
      LOAD_SHORT: load_len = LOAD_CNT_W'(LOAD_SHORT_CYC);
      LOAD_MED: load_len = LOAD_CNT_W'(LOAD_MED_CYC);
      LOAD_LONG: load_len = LOAD_CNT_W'(LOAD_LONG_CYC);
      default: load_len = LOAD_CNT_W'(1);
    endcase
  end

  // Code changes take effect at once; changes between nonzero codes keep the two-second frame running
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg + LOAD_CNT_W'(1);
    case (state_reg)
      LD_IDLE: begin
        cnt_next = '0;
        if (load_armed) begin
          state_next = LD_ON;
        end
      end
      LD_ON: begin
        if (cnt_reg >= load_len - LOAD_CNT_W'(1)) begin
          state_next = LD_REST;
        end
      end
      LD_REST: begin
        if (cnt_reg >= LOAD_CNT_W'(LOAD_PERIOD_CYC - 1)) begin
          state_next = LD_ON;
          cnt_next = '0;
        end
      end
      default: begin
        state_next = LD_IDLE;
        cnt_next = '0;
      end
    endcase
    if (!load_armed) begin
      state_next = LD_IDLE;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LD_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      input_load_on <= 1'b0;
    end else begin
      input_load_on <= (state_next == LD_ON);
    end
  end

  // Checking helpers
  logic post_written_reg;
  logic [LOAD_CNT_W-1:0] on_len_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      post_written_reg <= 1'b0;
    end else if (wr_en && hit_post) begin
      post_written_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      on_len_reg <= '0;
    end else if (input_load_on) begin
      on_len_reg <= on_len_reg + LOAD_CNT_W'(1);
    end else begin
      on_len_reg <= '0;
    end
  end

  reserved_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    pready && hit_post && !pwrite |-> prdata[7:6] == 2'h0)
    else $error("Reserved control bits read nonzero");

  load_done_only_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    input_load_on |-> $past(done_s))
    else $error("Input load applied outside charge done");

  load_none_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    load_sel == LOAD_NONE |=> !input_load_on)
    else $error("Input load applied with code none");

  load_length_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $fell(input_load_on) && $past(load_armed) && $stable(load_sel)
    |-> $past(on_len_reg) == load_len - LOAD_CNT_W'(1))
    else $error("Input load pulse has wrong length");

  bg_enable_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    wr_en && hit_post |=> background_charge_enable == $past(pwdata[3])
    && background_term_current == $past(pwdata[2:0]))
    else $error("Control write not applied to outputs");

  reset_value_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !post_written_reg |-> post_ctrl_view == 8'h01
    && !background_charge_enable && background_term_current == 3'h1)
    else $error("Control register lost reset value");

  mon_first_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    pready && hit_first && !pwrite
    |-> prdata[7:0] == $past(mon_first) && prdata[MF_TERM_BIT] == $past(term_s)
    && prdata[MF_CHG_LOOP_BIT] == $past(chg_loop_s))
    else $error("First monitor read mismatch");

  mon_second_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    pready && hit_second && !pwrite
    |-> prdata[7:0] == $past(mon_second) && prdata[1:0] == 2'h0
    && prdata[MS_BG_ACTIVE_BIT] == $past(bg_active_s))
    else $error("Second monitor read mismatch");

  pok_release_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    $rose(pok_release_reg) |-> $past(!bat_ok_s) ##1 !power_good_pin_oe)
    else $error("Power good released wrongly");

  unmapped_err_a: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    access && !hit_any |=> pready && pslverr)
    else $error("Unmapped access not flagged");

  load_pulse_c: cover property (
    @(posedge clk_sys) disable iff (!rst_n) $fell(input_load_on));

  mon_read_c: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    pready && hit_second && !pwrite);

  pok_release_c: cover property (
    @(posedge clk_sys) disable iff (!rst_n) $rose(pok_release_reg));

endmodule

// ---- dv/tb_top.sv ----
// Self-checking testbench for the charger register block
`timescale 1ns/1ps
module tb_top;
  import charger_regs_pkg::*;
  // Short load counts keep the run brief; period exceeds the longest load
  localparam int SH = 4;
  localparam int MD = 13;
  localparam int LG = 14;
  localparam int PER = 40;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [12:0] st = 13'h0000;
  logic done = 1'b0;
  logic low_req = 1'b0;
  logic pg_pin;
  logic pg_out;
  logic pg_oe;
  logic load_on;
  logic bg_en;
  logic [2:0] term;
  int err_total = 0;
  int total_checks = 0;
  logic [32:0] exp_q[$];
  string name_q[$];
  logic [32:0] mon_e;
  string mon_nm;
  logic [31:0] seed = 32'h0000_ff81;
  int cnt;
  int lens[4] = '{0, SH, MD, LG};

  always #50 clk_sys = ~clk_sys;

  // Open-drain pin with pull-up: low only while the block drives it
  assign pg_pin = pg_oe ? pg_out : 1'b1;

  charger_postcharge_monitor_regs #(.LOAD_SHORT_CYC(SH), .LOAD_MED_CYC(MD),
    .LOAD_LONG_CYC(LG), .LOAD_PERIOD_CYC(PER)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .termination_compare_flag(st[7]), .battery_below_input_flag(st[6]),
    .linear_trickle_active(st[5]), .die_hot_flag(st[4]),
    .charge_loop_flag(st[3]), .input_current_loop_flag(st[2]),
    .input_supply_ok(st[1]), .const_voltage_flag(st[0]),
    .gate_pin_state(st[12]), .battery_above_low_flag(st[11]),
    .disable_pin(st[10]), .battery_absent_flag(st[9]),
    .background_charge_active(st[8]), .charge_done_state(done),
    .power_good_pin_in(pg_pin), .power_good_low_req(low_req),
    .power_good_pin_out(pg_out), .power_good_pin_oe(pg_oe),
    .input_load_on(load_on), .background_charge_enable(bg_en),
    .background_term_current(term));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    y = y ^ (y << 5);
    return y;
  endfunction

  task automatic chk(input string nm, input logic [32:0] e,
                     input logic [32:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Expected answer is {pslverr, prdata}; the watcher compares it
  task automatic apb(input string nm, input logic w, input logic [7:0] a,
                     input logic [31:0] wd, input logic [32:0] e);
    int n;
    name_q.push_back(nm);
    exp_q.push_back(e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 20) chk("pready", 33'h1, 33'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Counts load cycles over one full period once the pattern is steady
  task automatic load_count(input int e);
    wait_cyc(50);
    cnt = 0;
    repeat (PER) begin
      @(posedge clk_sys);
      if (load_on === 1'b1) cnt++;
    end
    chk("load cycles", 33'(e), 33'(cnt));
  endtask

  always @(posedge clk_sys) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected answer", 33'h0, 33'h1);
      end else begin
        mon_nm = name_q.pop_front();
        mon_e = exp_q.pop_front();
        chk(mon_nm, mon_e, {pslverr, prdata});
      end
    end
  end

  initial begin
    #(100 * 6000);
    chk("watchdog", 33'h0, 33'h1);
    finish_test();
  end

  initial begin
    wait_cyc(3);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("term reset", 33'h1, {30'h0, term});
    chk("enable reset", 33'h0, {32'h0, bg_en});
    apb("ctrl reset", 1'b0, 8'h1c, 32'h0, 33'h0_0000_0001);
    apb("mon2 reset", 1'b0, 8'h44, 32'h0, 33'h0_0000_0020);
    $display("test reset done");

    apb("ctrl wr", 1'b1, 8'h1c, 32'hffff_ffff, 33'h0);
    apb("ctrl rd", 1'b0, 8'h1c, 32'h0, 33'h0_0000_003f);
    chk("enable set", 33'h1, {32'h0, bg_en});
    chk("term set", 33'h7, {30'h0, term});
    apb("ctrl wr0", 1'b1, 8'h1c, 32'h0000_0002, 33'h0);
    wait_cyc(1);
    chk("term two", 33'h2, {30'h0, term});
    chk("enable clr", 33'h0, {32'h0, bg_en});
    apb("unmapped", 1'b0, 8'h20, 32'h0, 33'h1_0000_0000);
    apb("misaligned", 1'b1, 8'h1d, 32'h0000_00ff, 33'h1_0000_0000);
    apb("ctrl kept", 1'b0, 8'h1c, 32'h0, 33'h0_0000_0002);
    $display("test control done");

    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      st <= seed[12:0];
      apb("mon1 wr", 1'b1, 8'h40, seed, 33'h0);
      wait_cyc(4);
      apb("mon1", 1'b0, 8'h40, 32'h0, {25'h0, st[7:0]});
      apb("mon2", 1'b0, 8'h44, 32'h0,
          {25'h0, st[12:11], 1'b1, st[10:8], 2'b00});
    end
    $display("test monitor done");

    st <= 13'h0800;
    low_req <= 1'b1;
    wait_cyc(4);
    chk("pin drive", 33'h1, {32'h0, pg_oe});
    chk("pin out", 33'h0, {32'h0, pg_out});
    apb("rel refused", 1'b1, 8'h44, 32'h0000_0020, 33'h0);
    wait_cyc(3);
    chk("pin kept", 33'h1, {32'h0, pg_oe});
    apb("mon2 low", 1'b0, 8'h44, 32'h0, 33'h0_0000_0040);
    st <= 13'h0000;
    wait_cyc(4);
    apb("rel", 1'b1, 8'h44, 32'h0000_0020, 33'h0);
    wait_cyc(3);
    chk("pin released", 33'h0, {32'h0, pg_oe});
    apb("mon2 rel", 1'b0, 8'h44, 32'h0, 33'h0_0000_0020);
    apb("rel clr", 1'b1, 8'h44, 32'h0, 33'h0);
    wait_cyc(3);
    chk("pin again", 33'h1, {32'h0, pg_oe});
    low_req <= 1'b0;
    $display("test power good done");

    done <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      apb("load wr", 1'b1, 8'h1c, {26'h0, 2'(c), 4'h9}, 33'h0);
      apb("load rd", 1'b0, 8'h1c, 32'h0, {27'h0, 2'(c), 4'h9});
      load_count(lens[c]);
    end
    done <= 1'b0;
    load_count(0);
    $display("test input load done");
    finish_test();
  end
endmodule
